/* adc_out_chk.sv */
`timescale 1ns/100ps
module adc_out_chk
    import adc_out_pkg::*;
(
    input wire logic                ref_clk,           // System clock.
    input wire logic                rst_n,             // Reset, active low.
    input wire logic                sample_clock_pos,  // Sampling clock.
    input wire logic                hw_reset_pin,      // Hardware reset.
    input wire logic                output_enable_pin, // Output enable pin.
    input wire logic [SAMPLE_W-1:0] sample_word,       // Output word.
    input wire logic                out_of_range_flag, // Full-scale flag.
    input wire logic                data_ready_clock,  // Output clock.
    input wire logic                data_oe,           // Output drive enable.
    input wire logic                dll_enable,        // Delay-lock loop enable.
    input wire logic                ref_only_mode      // Software power-down.
);
    logic [9:0] hw_cnt_reg;
    logic [3:0] hw_low_reg;
    logic       pin_reg;
    logic [7:0] idle_reg;

    // Hardware reset high time, and quiet time since it was last high.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_cnt_reg <= 10'h000;
            hw_low_reg <= 4'h0;
        end else if (hw_reset_pin) begin
            hw_cnt_reg <= (hw_cnt_reg == 10'h3FF) ? hw_cnt_reg : hw_cnt_reg + 10'h001;
            hw_low_reg <= 4'h0;
        end else begin
            hw_cnt_reg <= 10'h000;
            hw_low_reg <= (hw_low_reg == 4'hF) ? hw_low_reg : hw_low_reg + 4'h1;
        end
    end

    // Cycles since the sampling clock was last seen rising.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_reg  <= 1'b0;
            idle_reg <= 8'h00;
        end else begin
            pin_reg  <= sample_clock_pos;
            idle_reg <= (sample_clock_pos && !pin_reg) ? 8'h00 : (idle_reg == 8'hFF) ? idle_reg : idle_reg + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_pdn_outputs_off: assert property (ref_only_mode && $past(ref_only_mode) |-> !data_oe && !data_ready_clock)
        else $error("outputs driven in software power-down");
    a_auto_pd_off: assert property (idle_reg >= 8'd110 && hw_cnt_reg == 10'h000 && hw_low_reg == 4'hF |-> !data_oe)
        else $error("outputs driven with sampling clock absent");
    a_oe_pin_hiz: assert property ((!output_enable_pin && !hw_reset_pin) [*6] |-> !data_oe)
        else $error("outputs driven with output enable low");
    a_hw_reset_clears: assert property (hw_cnt_reg >= 10'd405 |-> sample_word == 12'h000 && !out_of_range_flag && !data_ready_clock)
        else $error("outputs not low during hardware reset");
    a_dll_default_on: assert property (hw_cnt_reg >= 10'd405 |-> dll_enable)
        else $error("loop not enabled by hardware reset");
    a_flag_full_scale: assert property (out_of_range_flag |-> sample_word inside {12'hFFF, 12'h000, 12'h7FF, 12'h800})
        else $error("flag set on an in-range word");
    a_flag_with_word: assert property ($changed(out_of_range_flag) && hw_cnt_reg == 10'h000 && hw_low_reg == 4'hF |-> idle_reg <= 8'd8)
        else $error("flag moved without its word");
    a_word_after_edge: assert property ($changed(sample_word) && hw_cnt_reg == 10'h000 && hw_low_reg == 4'hF |-> idle_reg <= 8'd8)
        else $error("word changed away from a sampling edge");

    c_power_down: cover property (ref_only_mode);
    c_hw_reset: cover property (hw_cnt_reg >= 10'd405);
    c_overrange: cover property ($rose(out_of_range_flag));
endmodule // adc_out_chk

bind adc_output_mode_control adc_out_chk adc_out_chk_i (.ref_clk, .rst_n, .sample_clock_pos, .hw_reset_pin,
    .output_enable_pin, .sample_word, .out_of_range_flag, .data_ready_clock, .data_oe, .dll_enable, .ref_only_mode);

/* adc_out_pkg.sv */
package adc_out_pkg;

    localparam int          SAMPLE_W        = 12;
    localparam logic [11:0] CODE_FULL_POS   = 12'hFFF;
    localparam logic [11:0] CODE_FULL_NEG   = 12'h000;
    localparam logic [11:0] CODE_TWOS_FLIP  = 12'h800;

    // Timing figures in their own units and the derived reference clock counts.
    localparam int REF_CLK_MHZ       = 200;
    localparam int SLOW_RATE_MSPS    = 2;
    localparam int SLOW_CYC          = REF_CLK_MHZ / SLOW_RATE_MSPS;
    localparam int DLL_MIN_RATE_MSPS = 60;
    localparam int DLL_MIN_CYC       = REF_CLK_MHZ / DLL_MIN_RATE_MSPS;
    localparam int HW_RESET_US       = 2;
    localparam int HW_RESET_CYC      = HW_RESET_US * REF_CLK_MHZ;
    localparam int LATENCY_HALF_CYC  = 35;
    localparam int PIPE_DEPTH        = (LATENCY_HALF_CYC - 1) / 2;
    localparam int PERIOD_W          = 8;
    localparam int HW_CNT_W          = 9;

    // Register map.
    localparam int         ADDR_W        = 8;
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

    localparam int         CTRL_PDN_BIT   = 0;
    localparam int         CTRL_DLL_BIT   = 1;
    localparam int         CTRL_MAP_LSB   = 2;
    localparam int         CTRL_W         = 10;
    localparam logic [7:0] FMT_MAP_RESET  = 8'hB1;
    localparam logic [9:0] CTRL_RESET     = {FMT_MAP_RESET, 1'b1, 1'b0};

    localparam int MAP_RISE_BIT = 0;
    localparam int MAP_TWOS_BIT = 1;

    localparam int STAT_DLL_BIT  = 0;
    localparam int STAT_PD_BIT   = 1;
    localparam int STAT_SLOW_BIT = 2;
    localparam int STAT_RISE_BIT = 3;
    localparam int STAT_TWOS_BIT = 4;
    localparam int STAT_SEL_LSB  = 5;
    localparam int STAT_OE_BIT   = 7;

    localparam int EV_OVR      = 0;
    localparam int EV_AUTO_PD  = 1;
    localparam int EV_DLL_RATE = 2;
    localparam int EV_HW_RESET = 3;
    localparam int EV_W        = 4;

    typedef enum logic [2:0] {
        PWR_RUN       = 3'b001,
        PWR_SW_DOWN   = 3'b010,
        PWR_AUTO_DOWN = 3'b100
    } pwr_state_t;

endpackage

/* adc_output_mode_control.sv */
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module adc_output_mode_control
    import adc_out_pkg::*;
(
    input  wire logic                ref_clk,             // System clock, 200 MHz.
    input  wire logic                rst_n,               // Asynchronous reset, active low.
    input  wire logic                sample_clock_pos,    // Sampling clock true pin.
    input  wire logic                sample_clock_neg,    // Sampling clock complement pin.
    input  wire logic                hw_reset_pin,        // Hardware reset pin, active high.
    input  wire logic                output_enable_pin,   // Output enable pin, active high.
    input  wire logic [1:0]          format_select_input, // Digitised four-level format select.
    input  wire logic [SAMPLE_W-1:0] core_code,           // Offset binary code from the converter core.
    input  wire logic                core_over_pos,       // Positive overdrive from the core.
    input  wire logic                core_over_neg,       // Negative overdrive from the core.
    input  wire logic [ADDR_W-1:0]   reg_addr,            // Register byte address.
    input  wire logic [31:0]         reg_wdata,           // Register write data.
    input  wire logic                reg_wr,              // Register write strobe.
    input  wire logic                reg_rd,              // Register read strobe.
    output logic [31:0]              reg_rdata,           // Read data, valid the cycle after reg_rd.
    output logic [SAMPLE_W-1:0]      sample_word,         // Parallel sample output.
    output logic                     out_of_range_flag,   // Full-scale indicator.
    output logic                     data_ready_clock,    // Output clock for the receiver.
    output logic                     data_oe,             // Output enable of word, flag and clock.
    output logic                     dll_enable,          // Delay-lock loop enable to the core.
    output logic                     ref_only_mode,       // Core powered down except the reference.
    output logic                     irq                  // Level interrupt.
);

    localparam int PIN_W = 4 + SAMPLE_W + 2;

    logic [PIN_W-1:0]          pin_s1_reg;
    logic [PIN_W-1:0]          pin_s2_reg;
    logic                      hw_pin;
    logic                      oe_pin;
    logic [1:0]                fmt_sel;
    logic [SAMPLE_W-1:0]       code_in;
    logic                      over_pos;
    logic                      over_neg;

    logic                      clk_level;
    logic                      rise_pulse;
    logic                      fall_pulse;
    logic                      clock_slow;
    logic [PERIOD_W-1:0]       period;

    logic [HW_CNT_W-1:0]       hw_cnt_reg;
    logic                      hw_rst;
    logic                      hw_rst_prev_reg;

    logic [CTRL_W-1:0]         ctrl_reg;
    logic [EV_W-1:0]           irq_stat_reg;
    logic [EV_W-1:0]           irq_mask_reg;
    logic [EV_W-1:0]           events;
    logic [EV_W-1:0]           w1c;

    pwr_state_t                pwr_reg;
    pwr_state_t                pwr_next;
    logic                      powered;

    logic [SAMPLE_W-1:0]       capture_reg;
    logic [SAMPLE_W-1:0]       pipe_reg [PIPE_DEPTH];
    logic [1:0]                entry;
    logic                      twos;
    logic                      rise_latch;
    logic                      out_update;

    // Pins from outside the clock domain pass two flip-flops first.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {hw_reset_pin, output_enable_pin, format_select_input, core_code,
                           core_over_pos, core_over_neg};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign hw_pin   = pin_s2_reg[PIN_W-1];
    assign oe_pin   = pin_s2_reg[PIN_W-2];
    assign fmt_sel  = pin_s2_reg[PIN_W-3 -: 2];
    assign code_in  = pin_s2_reg[SAMPLE_W+1:2];
    assign over_pos = pin_s2_reg[1];
    assign over_neg = pin_s2_reg[0];

    clock_monitor u_clock_monitor (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .clk_pos    (sample_clock_pos),
        .clk_neg    (sample_clock_neg),
        .clk_level  (clk_level),
        .rise_pulse (rise_pulse),
        .fall_pulse (fall_pulse),
        .clock_slow (clock_slow),
        .period     (period)
    );

    function automatic logic [1:0] map_entry(input logic [7:0] map, input logic [1:0] sel);
        return map[{sel, 1'b0} +: 2];
    endfunction

    function automatic logic [SAMPLE_W-1:0] to_format(input logic [SAMPLE_W-1:0] code, input logic is_twos);
        return is_twos ? (code ^ CODE_TWOS_FLIP) : code;
    endfunction

    // A hardware reset counts only once the pin has stayed high long enough.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_cnt_reg <= '0;
        end else if (!hw_pin) begin
            hw_cnt_reg <= '0;
        end else if (hw_cnt_reg != HW_CNT_W'(HW_RESET_CYC)) begin
            hw_cnt_reg <= hw_cnt_reg + HW_CNT_W'(1);
        end
    end

    assign hw_rst = hw_pin && (hw_cnt_reg == HW_CNT_W'(HW_RESET_CYC));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_rst_prev_reg <= 1'b0;
        end else begin
            hw_rst_prev_reg <= hw_rst;
        end
    end

    // Control register: power-down bit, loop enable and the format table.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (hw_rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl_reg <= reg_wdata[CTRL_W-1:0];
        end
    end

    assign dll_enable = ctrl_reg[CTRL_DLL_BIT];

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_RUN: begin
                if (ctrl_reg[CTRL_PDN_BIT]) begin
                    pwr_next = PWR_SW_DOWN;
                end else if (clock_slow) begin
                    pwr_next = PWR_AUTO_DOWN;
                end
            end
            PWR_SW_DOWN: begin
                if (!ctrl_reg[CTRL_PDN_BIT]) begin
                    pwr_next = clock_slow ? PWR_AUTO_DOWN : PWR_RUN;
                end
            end
            PWR_AUTO_DOWN: begin
                if (ctrl_reg[CTRL_PDN_BIT]) begin
                    pwr_next = PWR_SW_DOWN;
                end else if (!clock_slow) begin
                    pwr_next = PWR_RUN;
                end
            end
            default: begin
                pwr_next = PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= PWR_RUN;
        end else if (hw_rst) begin
            pwr_reg <= PWR_RUN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    assign powered       = (pwr_reg == PWR_RUN);
    assign ref_only_mode = (pwr_reg == PWR_SW_DOWN);

    // The core's clamped code is taken on the falling sampling edge.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_reg <= CODE_FULL_NEG;
        end else if (hw_rst) begin
            capture_reg <= CODE_FULL_NEG;
        end else if (fall_pulse && powered) begin
            if (over_pos) begin
                capture_reg <= CODE_FULL_POS;
            end else if (over_neg) begin
                capture_reg <= CODE_FULL_NEG;
            end else begin
                capture_reg <= code_in;
            end
        end
    end

    // Rising edges move samples along; half a cycle plus the depth gives the latency.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                pipe_reg[i] <= CODE_FULL_NEG;
            end
        end else if (hw_rst) begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                pipe_reg[i] <= CODE_FULL_NEG;
            end
        end else if (rise_pulse && powered) begin
            pipe_reg[0] <= capture_reg;
            for (int i = 1; i < PIPE_DEPTH; i++) begin
                pipe_reg[i] <= pipe_reg[i-1];
            end
        end
    end

    assign entry      = map_entry(ctrl_reg[CTRL_MAP_LSB +: 8], fmt_sel);
    assign twos       = entry[MAP_TWOS_BIT];
    assign rise_latch = entry[MAP_RISE_BIT];
    assign out_update = rise_pulse && powered;

    // Word and flag change together on the same sampling edge.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_word       <= '0;
            out_of_range_flag <= 1'b0;
        end else if (hw_rst) begin
            sample_word       <= '0;
            out_of_range_flag <= 1'b0;
        end else if (out_update) begin
            sample_word       <= to_format(pipe_reg[PIPE_DEPTH-1], twos);
            out_of_range_flag <= (pipe_reg[PIPE_DEPTH-1] == CODE_FULL_POS) ||
                                 (pipe_reg[PIPE_DEPTH-1] == CODE_FULL_NEG);
        end
    end

    // The data-ready edge chosen by the table sits mid-way through the data word.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ready_clock <= 1'b0;
        end else if (hw_rst || !powered) begin
            data_ready_clock <= 1'b0;
        end else begin
            data_ready_clock <= rise_latch ? ~clk_level : clk_level;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_oe <= 1'b1;
        end else if (hw_rst) begin
            data_oe <= 1'b1;
        end else begin
            data_oe <= oe_pin && powered;
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    assign events[EV_OVR]      = out_update && out_of_range_flag;
    assign events[EV_AUTO_PD]  = (pwr_next == PWR_AUTO_DOWN) && (pwr_reg != PWR_AUTO_DOWN);
    assign events[EV_DLL_RATE] = rise_pulse && dll_enable && !clock_slow &&
                                 (period > PERIOD_W'(DLL_MIN_CYC));
    assign events[EV_HW_RESET] = hw_rst_prev_reg && !hw_rst;

    assign w1c = (reg_wr && reg_addr == ADDR_IRQ_STAT) ? reg_wdata[EV_W-1:0] : '0;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= '0;
        end else if (hw_rst) begin
            irq_mask_reg <= '0;
        end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[EV_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read data stand for exactly one cycle; unmapped addresses read zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    reg_rdata <= {{(32-CTRL_W){1'b0}}, ctrl_reg};
                end
                ADDR_STATUS: begin
                    reg_rdata <= '0;
                    reg_rdata[STAT_DLL_BIT]        <= dll_enable;
                    reg_rdata[STAT_PD_BIT]         <= !powered;
                    reg_rdata[STAT_SLOW_BIT]       <= clock_slow;
                    reg_rdata[STAT_RISE_BIT]       <= rise_latch;
                    reg_rdata[STAT_TWOS_BIT]       <= twos;
                    reg_rdata[STAT_SEL_LSB +: 2]   <= fmt_sel;
                    reg_rdata[STAT_OE_BIT]         <= data_oe;
                end
                ADDR_IRQ_STAT: begin
                    reg_rdata <= {{(32-EV_W){1'b0}}, irq_stat_reg};
                end
                ADDR_IRQ_MASK: begin
                    reg_rdata <= {{(32-EV_W){1'b0}}, irq_mask_reg};
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule // adc_output_mode_control

/* capture_model.sv */
`timescale 1ns/100ps
module capture_model
    import adc_out_pkg::*;
(
    input  wire logic [SAMPLE_W-1:0] sample_word,      // Word from the block.
    input  wire logic                data_ready_clock, // Output clock from the block.
    input  wire logic                data_oe,          // Block drives the pins.
    input  wire logic                rise_latch,       // Latch on the rising output clock edge.
    output logic [SAMPLE_W-1:0]      cap_word          // Last word latched.
);
    // Released pins do not keep their value, so an undriven bus reads inverted.
    wire [SAMPLE_W-1:0] word_pin = data_oe ? sample_word : ~sample_word;
    wire                strobe   = rise_latch ? data_ready_clock : ~data_ready_clock;

    always @(posedge strobe) cap_word <= word_pin;
endmodule // capture_model

/* clock_monitor.sv */
`timescale 1ns/100ps
module clock_monitor
    import adc_out_pkg::*;
(
    input  wire logic                ref_clk,      // System clock.
    input  wire logic                rst_n,        // Asynchronous reset, active low.
    input  wire logic                clk_pos,      // Sampling clock, true pin.
    input  wire logic                clk_neg,      // Sampling clock, complement pin.
    output logic                     clk_level,    // Synchronised sampling clock level.
    output logic                     rise_pulse,   // One-cycle pulse, three cycles after a rising edge.
    output logic                     fall_pulse,   // One-cycle pulse, three cycles after a falling edge.
    output logic                     clock_slow,   // No rising edge within the slow limit.
    output logic [PERIOD_W-1:0]      period        // Last measured period in cycles.
);

    logic [1:0]          pos_sync_reg;
    logic [1:0]          neg_sync_reg;
    logic                level_prev_reg;
    logic [PERIOD_W-1:0] cnt_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_sync_reg <= 2'h0;
            neg_sync_reg <= 2'h0;
        end else begin
            pos_sync_reg <= {pos_sync_reg[0], clk_pos};
            neg_sync_reg <= {neg_sync_reg[0], clk_neg};
        end
    end

    // A single-ended clock with the complement pin grounded also works here.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_level      <= 1'b0;
            level_prev_reg <= 1'b0;
        end else begin
            clk_level      <= pos_sync_reg[1] & ~neg_sync_reg[1];
            level_prev_reg <= clk_level;
        end
    end

    assign rise_pulse = clk_level & ~level_prev_reg;
    assign fall_pulse = ~clk_level & level_prev_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg    <= '0;
            period     <= '0;
            clock_slow <= 1'b1;
        end else if (rise_pulse) begin
            cnt_reg    <= PERIOD_W'(1);
            period     <= cnt_reg;
            clock_slow <= 1'b0;
        end else if (cnt_reg >= PERIOD_W'(SLOW_CYC)) begin
            clock_slow <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + PERIOD_W'(1);
        end
    end

endmodule // clock_monitor

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top
    import adc_out_pkg::*;
;
    logic                ref_clk             = 1'b0;
    logic                rst_n               = 1'b0;
    logic                sample_clock_pos    = 1'b0;
    logic                sample_clock_neg    = 1'b0;
    logic                hw_reset_pin        = 1'b0;
    logic                output_enable_pin   = 1'b1;
    logic [1:0]          format_select_input = 2'h0;
    logic [SAMPLE_W-1:0] core_code           = 12'h000;
    logic                core_over_pos       = 1'b0;
    logic                core_over_neg       = 1'b0;
    logic [ADDR_W-1:0]   reg_addr            = 8'h00;
    logic [31:0]         reg_wdata           = 32'h0;
    logic                reg_wr              = 1'b0;
    logic                reg_rd              = 1'b0;
    logic [31:0]         reg_rdata;
    logic [SAMPLE_W-1:0] sample_word, cap_word;
    logic                out_of_range_flag, data_ready_clock, data_oe, dll_enable, ref_only_mode, irq;
    logic                samp_on = 1'b0, chk_en = 1'b0, cur_twos = 1'b0, cur_rise = 1'b1;
    int                  num_errors = 0, num_checks = 0, nfall = 0, cycles = 0;
    logic [11:0]         tbl_ctrl [5] = '{12'h2C4, 12'h2C4, 12'h2C4, 12'h2C4, 12'h2C8};
    logic [3:0]          tbl_mode [5] = '{4'h1, 4'h4, 4'hB, 4'hE, 4'h2};

    adc_output_mode_control adc_output_mode_control_i (.ref_clk, .rst_n, .sample_clock_pos, .sample_clock_neg,
        .hw_reset_pin, .output_enable_pin, .format_select_input, .core_code, .core_over_pos, .core_over_neg,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_word, .out_of_range_flag,
        .data_ready_clock, .data_oe, .dll_enable, .ref_only_mode, .irq);
    capture_model capture_model_i (.sample_word, .data_ready_clock, .data_oe, .rise_latch(cur_rise), .cap_word);

    always #2.5 ref_clk = ~ref_clk;
    always #40 sample_clock_pos = samp_on ? ~sample_clock_pos : 1'b0;
    always @(negedge sample_clock_pos) nfall <= nfall + 1;
    always @(posedge sample_clock_pos) begin
        core_code     <= 12'(nfall * 309);
        core_over_pos <= (nfall % 8 == 5);
        core_over_neg <= (nfall % 8 == 6);
    end

    function automatic logic [11:0] clamp_of(input int k);
        return (k % 8 == 5) ? 12'hFFF : (k % 8 == 6) ? 12'h000 : 12'(k * 309);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & m, e);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Sample k leaves on the rising edge that follows falling edge k+18.
    always @(posedge sample_clock_pos) if (chk_en) begin
        repeat (6) @(posedge ref_clk);
        check(sample_word, clamp_of(nfall - 18) ^ (cur_twos ? CODE_TWOS_FLIP : 12'h000));
        check(out_of_range_flag, clamp_of(nfall - 18) inside {12'hFFF, 12'h000});
        check(data_ready_clock, !cur_rise);
        check(cap_word, clamp_of(nfall - 19) ^ (cur_twos ? CODE_TWOS_FLIP : 12'h000));
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h2C6);
        rd(8'h10, 32'hFFFFFFFF, 32'h0);
        settle(130);
        check(data_oe, 1'b0);
        rd(ADDR_STATUS, 32'h6, 32'h6);
        rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
        $display("test reset and idle clock done");
        samp_on = 1'b1;
        wr(ADDR_IRQ_MASK, 32'h2);
        check(irq, 1'b1);
        settle(200);
        wr(ADDR_IRQ_STAT, 32'h2);
        check(irq, 1'b0);
        check(data_oe, 1'b1);
        wr(ADDR_IRQ_MASK, 32'h4);
        check(irq, 1'b1);
        wr(ADDR_CTRL, 32'h2C4);
        check(dll_enable, 1'b0);
        settle(40);
        wr(ADDR_IRQ_STAT, 32'h4);
        check(irq, 1'b0);
        $display("test interrupts and loop mode done");
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL, {20'h0, tbl_ctrl[i]});
            format_select_input <= tbl_mode[i][3:2];
            {cur_twos, cur_rise} = tbl_mode[i][1:0];
            repeat (22) @(negedge sample_clock_pos);
            chk_en = 1'b1;
            repeat (10) @(negedge sample_clock_pos);
            chk_en = 1'b0;
            rd(ADDR_STATUS, 32'hF8, {24'h0, 1'b1, tbl_mode[i][3:2], cur_twos, cur_rise, 3'h0});
        end
        rd(ADDR_IRQ_STAT, 32'h1, 32'h1);
        $display("test formats and latency done");
        wr(ADDR_CTRL, 32'h2C5);
        settle(4);
        check({ref_only_mode, data_oe}, 2'b10);
        rd(ADDR_STATUS, 32'h2, 32'h2);
        wr(ADDR_CTRL, 32'h2C4);
        settle(40);
        check({ref_only_mode, data_oe}, 2'b01);
        @(posedge ref_clk) output_enable_pin <= 1'b0;
        settle(6);
        check(data_oe, 1'b0);
        @(posedge ref_clk) output_enable_pin <= 1'b1;
        settle(6);
        check(data_oe, 1'b1);
        $display("test power-down and output enable done");
        @(posedge ref_clk) hw_reset_pin <= 1'b1;
        settle(420);
        check({sample_word, out_of_range_flag, dll_enable}, {12'h000, 1'b0, 1'b1});
        @(posedge ref_clk) hw_reset_pin <= 1'b0;
        settle(4);
        rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h2C6);
        rd(ADDR_IRQ_STAT, 32'h8, 32'h8);
        rd(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
        $display("test hardware reset done");
        wr(ADDR_IRQ_STAT, 32'h2);
        wr(ADDR_IRQ_MASK, 32'h2);
        samp_on = 1'b0;
        settle(130);
        check({data_oe, irq}, 2'b01);
        wr(ADDR_IRQ_STAT, 32'h2);
        check(irq, 1'b0);
        $display("test clock loss done");
        tally_and_finish();
    end
endmodule // tb_top
